// ==== core/rx_mf_device.sv ====
`timescale 1ns/10ps
module rx_mf_device (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sample stream
   input wire logic sample_vld_i,
   input wire logic signed [14:0] subcarrier_filter_out_i,
   input wire logic signed [14:0] phase_shift_filter_out_i,
   input wire logic receiver_serial_bit_i,
   input wire logic tx_active_i,
   // Decoder side
   output logic [14:0] sync_out_o,
   output logic sync_vld_o,
   // Link
   rx_mf_if.device lnk
);
   // ----------------------------------------
   // Registers and datapath state
   // ----------------------------------------
   logic [31:0] tech_q;
   logic [31:0] strength_q;
   logic signed [18:0] avg_acc_q;
   logic [1:0] avg_cnt_q;
   logic [14:0] sync_q;
   logic sync_vld_q;
   logic above_q;
   logic start_q;
   logic tx_q;
   // ----------------------------------------
   // Named wires
   // ----------------------------------------
   wire tech_hit;
   wire strength_hit;
   wire tech_wr;
   wire strength_wr;
   wire [1:0] gain_field;
   wire [6:0] thr_field;
   wire [1:0] gain_eff;
   wire [6:0] thr_eff;
   wire [14:0] thr_wide;
   wire signed [15:0] sub_term;
   wire signed [15:0] phase_term;
   wire signed [15:0] comb;
   wire signed [18:0] scaled;
   wire signed [18:0] part;
   wire signed [18:0] acc_d;
   wire [14:0] avg_mag;
   wire last_of_four;
   wire avg_done;
   wire exceed;
   wire above_d;
   wire start_d;
   wire obs_high_hit;
   wire obs_tx_hit;
   wire obs_low_hit;
   wire [7:0] sync_low_byte;
   wire [6:0] sync_high_bits;
   wire [7:0] tx_group;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Accumulator magnitude, saturated to 15 bits
   function automatic logic [14:0] mag15(input logic signed [18:0] v);
      logic [18:0] a;
      a = v[18] ? 19'(-v) : 19'(v);
      return (a[18:15] != 4'h0) ? 15'h7FFF : a[14:0];
   endfunction
   // Register port address match
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction
   // ----------------------------------------
   // Register port
   // ----------------------------------------
   assign tech_hit = hit(lnk.reg_addr, rx_mf_pkg::REG_RX_TECH);
   assign strength_hit = hit(lnk.reg_addr, rx_mf_pkg::REG_SIG_STRENGTH);
   assign tech_wr = lnk.reg_wr && tech_hit;
   assign strength_wr = lnk.reg_wr && strength_hit;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         tech_q <= rx_mf_pkg::RX_TECH_RST;
      else if (tech_wr)
         tech_q <= lnk.reg_wdata;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         strength_q <= rx_mf_pkg::SIG_STRENGTH_RST;
      else if (strength_wr)
         strength_q <= {25'h0, lnk.reg_wdata[rx_mf_pkg::THR_MSB:rx_mf_pkg::THR_LSB]};
   end
   assign lnk.reg_rdata = tech_hit ? tech_q :
                          strength_hit ? strength_q : 32'h0;
   // ----------------------------------------
   // Gain, combine and averaging
   // ----------------------------------------
   assign gain_field = tech_q[rx_mf_pkg::GAIN_MSB:rx_mf_pkg::GAIN_LSB];
   assign thr_field = strength_q[rx_mf_pkg::THR_MSB:rx_mf_pkg::THR_LSB];
   assign gain_eff = lnk.lut_gain_vld ? lnk.lut_gain : gain_field;
   assign thr_eff = lnk.lut_thr_vld ? lnk.lut_thr : thr_field;
   assign sub_term = 16'(subcarrier_filter_out_i);
   // Second filter only feeds the sum in phase-shift mode
   assign phase_term = lnk.psk_mode ? 16'(phase_shift_filter_out_i) : 16'sh0;
   assign comb = sub_term + phase_term;
   assign scaled = 19'(comb) <<< gain_eff;
   // Sum of four quarters needs the full 19 bits at gain 3
   assign part = scaled >>> 2;
   assign acc_d = (avg_cnt_q == 2'h0) ? part : avg_acc_q + part;
   assign avg_mag = mag15(acc_d);
   assign last_of_four = avg_cnt_q == 2'h3;
   assign avg_done = sample_vld_i && last_of_four;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         avg_acc_q <= 19'sh0;
         avg_cnt_q <= 2'h0;
      end
      else if (sample_vld_i)
      begin
         avg_acc_q <= acc_d;
         avg_cnt_q <= avg_cnt_q + 2'h1;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sync_q <= 15'h0;
         sync_vld_q <= 1'b0;
      end
      else
      begin
         sync_vld_q <= avg_done;
         if (avg_done)
            sync_q <= avg_mag;
      end
   end
   // ----------------------------------------
   // Signal detection
   // ----------------------------------------
   assign thr_wide = {8'h0, thr_eff};
   assign exceed = avg_mag > thr_wide;
   // Level held between averages, so start fires once per crossing
   assign above_d = avg_done ? exceed : above_q;
   assign start_d = avg_done && exceed && !above_q;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         above_q <= 1'b0;
         start_q <= 1'b0;
      end
      else
      begin
         above_q <= above_d;
         start_q <= start_d;
      end
   end
   // ----------------------------------------
   // Transmitter activity
   // ----------------------------------------
   // Registered copy feeds the capture trigger
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         tx_q <= 1'b0;
      else
         tx_q <= tx_active_i;
   end
   assign tx_group = 8'(tx_q) << rx_mf_pkg::TX_ACTIVE_BIT;
   // ----------------------------------------
   // Observation groups
   // ----------------------------------------
   assign sync_low_byte = sync_q[7:0];
   assign sync_high_bits = sync_q[14:8];
   assign obs_high_hit = lnk.obs_sel_high == rx_mf_pkg::OBS_GROUP_HIGH;
   assign obs_tx_hit = lnk.obs_sel_high == rx_mf_pkg::OBS_TX_ENCODER;
   assign obs_low_hit = lnk.obs_sel_low == rx_mf_pkg::OBS_GROUP_LOW;
   assign sync_out_o = sync_q;
   assign sync_vld_o = sync_vld_q;
   assign lnk.decoder_start = start_q;
   assign lnk.tx_active = tx_q;
   assign lnk.obs_high = obs_high_hit ? sync_low_byte :
                         obs_tx_hit ? tx_group : 8'h0;
   // Serial data bit rides in the top position of the second group
   assign lnk.obs_low = obs_low_hit ? {receiver_serial_bit_i, sync_high_bits} : 8'h0;
endmodule // rx_mf_device

// ==== core/rx_mf_pkg.sv ====
package rx_mf_pkg;
   // ----------------------------------------
   // Device register map (index = offset)
   // ----------------------------------------
   localparam logic [7:0] REG_RX_TECH = 8'h22;
   localparam logic [7:0] REG_SIG_STRENGTH = 8'h30;
   localparam int GAIN_LSB = 15;
   localparam int GAIN_MSB = 16;
   localparam int THR_LSB = 0;
   localparam int THR_MSB = 6;
   localparam logic [31:0] RX_TECH_RST = 32'h0000_0000;
   localparam logic [31:0] SIG_STRENGTH_RST = 32'h0000_007F;
   // ----------------------------------------
   // Observation and capture constants
   // ----------------------------------------
   localparam logic [7:0] OBS_GROUP_HIGH = 8'h16;
   localparam logic [7:0] OBS_GROUP_LOW = 8'h15;
   localparam logic [7:0] OBS_TX_ENCODER = 8'h29;
   localparam int TX_ACTIVE_BIT = 4;
   localparam logic [1:0] CAPTURE_RATE_CODE = 2'h1;
   localparam logic [4:0] CAPTURE_SIZE_CODE = 5'h1F;
   localparam int CAPTURE_DELAY_US = 90;
   localparam int CLK_MHZ = 10;
   localparam int CAPTURE_DELAY_CYC = CAPTURE_DELAY_US * CLK_MHZ;
   localparam logic [3:0] AVG_LEN_LOG2 = 4'h2;
   // ----------------------------------------
   // Controller APB register map
   // ----------------------------------------
   localparam logic [11:0] APB_CTRL = 12'h000;
   localparam logic [11:0] APB_GAIN = 12'h004;
   localparam logic [11:0] APB_THR = 12'h008;
   localparam logic [11:0] APB_STATUS = 12'h00C;
   localparam logic [11:0] APB_MASK = 12'h010;
   localparam logic [11:0] APB_LAST = 12'h014;
   localparam logic [11:0] APB_CAPTURE = 12'h018;
   localparam int EV_START = 0;
   localparam int EV_CAPTURE = 1;
   localparam int EV_W = 2;
endpackage

// ==== core/rx_mf_if.sv ====
`timescale 1ns/10ps
interface rx_mf_if;
   // Register port
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   // Lookup table overrides
   logic lut_gain_vld;
   logic [1:0] lut_gain;
   logic lut_thr_vld;
   logic [6:0] lut_thr;
   // Mode, trigger and observation
   logic psk_mode;
   logic tx_active;
   logic [7:0] obs_sel_high;
   logic [7:0] obs_sel_low;
   logic [7:0] obs_high;
   logic [7:0] obs_low;
   logic decoder_start;
   modport device (
      input reg_wr, reg_addr, reg_wdata, lut_gain_vld, lut_gain, lut_thr_vld, lut_thr,
      input psk_mode, obs_sel_high, obs_sel_low,
      output reg_rdata, tx_active, obs_high, obs_low, decoder_start
   );
   modport host (
      output reg_wr, reg_addr, reg_wdata, lut_gain_vld, lut_gain, lut_thr_vld, lut_thr,
      output psk_mode, obs_sel_high, obs_sel_low,
      input reg_rdata, tx_active, obs_high, obs_low, decoder_start
   );
endinterface

// ==== core/rx_mf_host.sv ====
`timescale 1ns/10ps
module rx_mf_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq_o,
   // Link
   rx_mf_if.host lnk
);
   logic [31:0] ctrl_q;
   logic [1:0] gain_q;
   logic [6:0] thr_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic [14:0] last_q;
   logic cap_armed_q;
   logic cap_run_q;
   logic [9:0] cap_cnt_q;
   logic tx_d1_q;
   logic [31:0] rdata_d;
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire gain_sel = paddr == rx_mf_pkg::APB_GAIN;
   wire tx_fall = tx_d1_q && !lnk.tx_active;
   wire cap_done = cap_run_q && cap_cnt_q == 10'(rx_mf_pkg::CAPTURE_DELAY_CYC);
   wire [1:0] ev = {cap_done, lnk.decoder_start};
   // ----------------------------------------
   // Link drive
   // ----------------------------------------
   // ctrl: b0 psk, b1 gain lut valid, b2 thr lut valid, b3 arm capture, b4 write device
   assign lnk.psk_mode = ctrl_q[0];
   assign lnk.lut_gain_vld = ctrl_q[1];
   assign lnk.lut_gain = gain_q;
   assign lnk.lut_thr_vld = ctrl_q[2];
   assign lnk.lut_thr = thr_q;
   assign lnk.obs_sel_high = rx_mf_pkg::OBS_GROUP_HIGH;
   assign lnk.obs_sel_low = rx_mf_pkg::OBS_GROUP_LOW;
   // Gain write with b4 set goes to the device register, else to the lookup value
   assign lnk.reg_wr = wr && (paddr == rx_mf_pkg::APB_THR || (gain_sel && ctrl_q[4]));
   assign lnk.reg_addr = gain_sel ? rx_mf_pkg::REG_RX_TECH : rx_mf_pkg::REG_SIG_STRENGTH;
   assign lnk.reg_wdata = gain_sel ? 32'(pwdata[1:0]) << rx_mf_pkg::GAIN_LSB :
                          {25'h0, pwdata[6:0]};
   // ----------------------------------------
   // APB
   // ----------------------------------------
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign irq_o = |(status_q & mask_q);
   always_comb
   begin
      case (paddr)
         rx_mf_pkg::APB_CTRL: rdata_d = ctrl_q;
         rx_mf_pkg::APB_GAIN: rdata_d = {30'h0, gain_q};
         rx_mf_pkg::APB_THR: rdata_d = lnk.reg_rdata;
         rx_mf_pkg::APB_STATUS: rdata_d = {30'h0, status_q};
         rx_mf_pkg::APB_MASK: rdata_d = {30'h0, mask_q};
         rx_mf_pkg::APB_LAST: rdata_d = {17'h0, last_q};
         rx_mf_pkg::APB_CAPTURE: rdata_d = {25'h0, rx_mf_pkg::CAPTURE_SIZE_CODE,
                                            rx_mf_pkg::CAPTURE_RATE_CODE};
         default: rdata_d = 32'h0;
      endcase
   end
   assign prdata = rdata_d;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= 32'h0;
         gain_q <= 2'h0;
         thr_q <= 7'h7F;
         status_q <= 2'h0;
         mask_q <= 2'h0;
         last_q <= 15'h0;
         cap_armed_q <= 1'b0;
         cap_run_q <= 1'b0;
         cap_cnt_q <= 10'h0;
         tx_d1_q <= 1'b0;
      end
      else
      begin
         tx_d1_q <= lnk.tx_active;
         if (wr && paddr == rx_mf_pkg::APB_CTRL)
            ctrl_q <= pwdata;
         if (wr && gain_sel && !ctrl_q[4])
            gain_q <= pwdata[1:0];
         if (wr && paddr == rx_mf_pkg::APB_THR)
            thr_q <= pwdata[6:0];
         if (wr && paddr == rx_mf_pkg::APB_MASK)
            mask_q <= pwdata[1:0];
         status_q <= ((rd && paddr == rx_mf_pkg::APB_STATUS) ? 2'h0 : status_q) | ev;
         // Post trigger, first falling edge only
         if (wr && paddr == rx_mf_pkg::APB_CTRL && pwdata[3])
            cap_armed_q <= 1'b1;
         else if (cap_armed_q && tx_fall)
         begin
            cap_armed_q <= 1'b0;
            cap_run_q <= 1'b1;
            cap_cnt_q <= 10'h0;
         end
         else if (cap_done)
            cap_run_q <= 1'b0;
         else if (cap_run_q)
            cap_cnt_q <= cap_cnt_q + 10'h1;
         if (cap_done)
            last_q <= {lnk.obs_low[6:0], lnk.obs_high};
      end
   end
endmodule // rx_mf_host

// ==== test/rx_mf_properties.sv ====
`timescale 1ns/10ps
module rx_mf_properties (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link signals
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic lut_thr_vld,
   input wire logic [6:0] lut_thr,
   input wire logic [7:0] obs_sel_high,
   input wire logic [7:0] obs_sel_low,
   input wire logic [7:0] obs_high,
   input wire logic [7:0] obs_low,
   input wire logic decoder_start
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [6:0] thr_q;
   logic [1:0] gain_q;
   wire logic [6:0] thr = lut_thr_vld ? lut_thr : thr_q;
   wire logic [14:0] seen = {obs_low[6:0], obs_high};
   wire logic obs_on = obs_sel_high == 8'h16 && obs_sel_low == 8'h15;
   wire logic wr_thr = reg_wr && reg_addr == 8'h30;
   // Shadow of device threshold and gain
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         thr_q <= 7'h7F;
         gain_q <= 2'h0;
      end
      else
      begin
         if (wr_thr)
            thr_q <= reg_wdata[6:0];
         if (reg_wr && reg_addr == 8'h22)
            gain_q <= reg_wdata[16:15];
      end
   end
   sequence s_thr_write;
      wr_thr;
   endsequence
   sequence s_thr_read;
      reg_addr == 8'h30;
   endsequence
   a_start_single: assert property (decoder_start |=> !decoder_start)
      else $error("start pulse too long");
   a_start_gap: assert property (decoder_start |=> !decoder_start [*3])
      else $error("start inside one average");
   a_start_exceeds: assert property (decoder_start && obs_on |-> seen > {8'h00, $past(thr)})
      else $error("start without exceed");
   a_start_fresh: assert property (decoder_start && $past(obs_on)
      |-> $past(seen) <= {8'h00, $past(thr)})
      else $error("start on later sample");
   a_thr_read: assert property (s_thr_read |-> reg_rdata[6:0] == thr_q)
      else $error("threshold readback");
   a_thr_take: assert property (s_thr_write ##1 s_thr_read
      |-> reg_rdata[6:0] == $past(reg_wdata[6:0]))
      else $error("threshold write lost");
   a_gain_read: assert property (reg_addr == 8'h22 |-> reg_rdata[16:15] == gain_q)
      else $error("gain readback");
   a_write_pulse: assert property (reg_wr |=> !reg_wr)
      else $error("register write held");
endmodule // rx_mf_properties

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic irq_o;
   logic vld;
   logic [14:0] sync;
   logic sample_vld_i = 1'b0;
   logic tx_active_i = 1'b0;
   logic ser = 1'b0;
   logic signed [14:0] sc = 15'h0000;
   logic signed [14:0] ph = 15'h0000;
   int bad_count = 0;
   int total_checks = 0;
   int n;
   always #50 clk_i = ~clk_i;
   rx_mf_if lnk ();
   rx_mf_device u_rx_mf_device (.clk_i(clk_i), .rst_i(rst_i), .sample_vld_i(sample_vld_i),
      .subcarrier_filter_out_i(sc), .phase_shift_filter_out_i(ph), .receiver_serial_bit_i(ser),
      .tx_active_i(tx_active_i), .sync_out_o(sync), .sync_vld_o(vld), .lnk(lnk.device));
   rx_mf_host u_rx_mf_host (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .irq_o(irq_o), .lnk(lnk.host));
   rx_mf_properties u_rx_mf_properties (.clk_i(clk_i), .rst_i(rst_i), .reg_wr(lnk.reg_wr),
      .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata),
      .lut_thr_vld(lnk.lut_thr_vld), .lut_thr(lnk.lut_thr), .obs_sel_high(lnk.obs_sel_high),
      .obs_sel_low(lnk.obs_sel_low), .obs_high(lnk.obs_high), .obs_low(lnk.obs_low),
      .decoder_start(lnk.decoder_start));
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk_i);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         bad_count++;
         close_out();
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, e, rd);
   endtask
   // Four equal samples, then the averaged result
   task automatic send(input logic [14:0] a, input logic [14:0] b, input logic [14:0] e,
      input logic st);
      repeat (4)
      begin
         @(posedge clk_i);
         sample_vld_i <= 1'b1;
         sc <= a;
         ph <= b;
      end
      @(posedge clk_i);
      sample_vld_i <= 1'b0;
      @(posedge clk_i);
      chk("sync valid", 32'h1, {31'h0, vld});
      chk("sync", {17'h0, e}, {17'h0, sync});
      chk("observe", {16'h0, ser, e}, {16'h0, lnk.obs_low, lnk.obs_high});
      chk("start", {31'h0, st}, {31'h0, lnk.decoder_start});
      ser <= ~ser;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(12'h008, 32'h0000_007F, "threshold");
      rchk(12'h00C, 32'h0000_0000, "status");
      apb(1'b1, 12'h000, 32'h0000_0002);
      for (int g = 0; g < 4; g++)
      begin
         apb(1'b1, 12'h004, 32'(g));
         send(15'h0064, 15'h0030, 15'(15'h0064 << g), g == 1);
      end
      apb(1'b1, 12'h000, 32'h0000_0012);
      apb(1'b1, 12'h004, 32'h0000_0002);
      send(15'h0064, 15'h0030, 15'h0320, 1'b0);
      rchk(12'h004, 32'h0000_0003, "lookup gain");
      apb(1'b1, 12'h000, 32'h0000_0010);
      send(15'h0064, 15'h0030, 15'h0190, 1'b0);
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0001);
      send(15'h0064, 15'h0030, 15'h0094, 1'b0);
      send(15'h7F9C, 15'h7FD0, 15'h0094, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0000);
      send(15'h0064, 15'h0030, 15'h0064, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_0030);
      rchk(12'h008, 32'h0000_0030, "threshold");
      apb(1'b1, 12'h000, 32'h0000_0004);
      send(15'h0030, 15'h0000, 15'h0030, 1'b0);
      send(15'h0034, 15'h0000, 15'h0034, 1'b1);
      send(15'h0034, 15'h0000, 15'h0034, 1'b0);
      rchk(12'h010, 32'h0000_0000, "mask");
      chk("irq masked", 32'h0, {31'h0, irq_o});
      apb(1'b1, 12'h010, 32'h0000_0001);
      @(posedge clk_i);
      chk("irq", 32'h1, {31'h0, irq_o});
      rchk(12'h00C, 32'h0000_0001, "status");
      @(posedge clk_i);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      apb(1'b1, 12'h000, 32'h0000_0008);
      tx_active_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      tx_active_i <= 1'b0;
      repeat (rx_mf_pkg::CAPTURE_DELAY_CYC - 10) @(posedge clk_i);
      rchk(12'h00C, 32'h0000_0000, "capture early");
      repeat (20) @(posedge clk_i);
      rchk(12'h00C, 32'h0000_0002, "capture done");
      rchk(12'h014, 32'h0000_0034, "capture word");
      rchk(12'h018, 32'h0000_007D, "capture codes");
      apb(1'b1, 12'h100, 32'hFFFF_FFFF);
      rchk(12'h100, 32'h0000_0000, "unmapped");
      rchk(12'h008, 32'h0000_0030, "threshold kept");
      close_out();
   end
endmodule // testbench
